// [rtl/ogr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// identifier, rom mapping and posted-write error register bank
module ogr_regs
  import ogr_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  pcie_rst_b,
  input  wire ogr_pkg::ogr_req_s     bus_req,
  output logic      [31:0]           rdata,
  output logic                       rvalid,
  input  wire logic                  eeprom_present,
  input  wire logic                  eeprom_load,
  input  wire logic [63:0]           eeprom_id,
  input  wire logic                  rom_rd_req,
  input  wire logic [47:0]           rom_rd_offset,
  output logic      [31:0]           rom_host_addr,
  output logic                       rom_host_valid,
  input  wire logic                  fail_event,
  input  wire ogr_pkg::ogr_fail_s    fail_info,
  output logic      [63:0]           unique_id,
  output logic                       id_valid
);
  import ogr_pkg::*;

  // -----------------------------------------------------------------
  // combined reset: pcie reset or global/power-on reset
  // -----------------------------------------------------------------
  // the pcie reset also clears everything the global reset clears, except the low nibble of each identifier quadlet
  wire any_rst_b = rst_b & pcie_rst_b;   // see RQ5

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire hit_upper = (bus_req.addr == OGR_OFF_ID_UPPER);
  wire hit_lower = (bus_req.addr == OGR_OFF_ID_LOWER);
  wire hit_rom   = (bus_req.addr == OGR_OFF_ROM_BASE);
  wire hit_flo   = (bus_req.addr == OGR_OFF_FAIL_LOW);
  wire hit_fhi   = (bus_req.addr == OGR_OFF_FAIL_HIGH);

  // -----------------------------------------------------------------
  // identifier load selection
  // -----------------------------------------------------------------
  // with an eeprom fitted only its loader may write; software is ignored
  wire         fw_wr_upper = bus_req.wr & hit_upper & ~eeprom_present;
  wire         fw_wr_lower = bus_req.wr & hit_lower & ~eeprom_present;
  wire         ee_take     = eeprom_present & eeprom_load;              // see RQ3
  wire         ld_upper    = ee_take | fw_wr_upper;                     // see RQ4
  wire         ld_lower    = ee_take | fw_wr_lower;                     // see RQ4
  wire [31:0]  ld_upper_d  = ee_take ? eeprom_id[63:32] : bus_req.wdata;
  wire [31:0]  ld_lower_d  = ee_take ? eeprom_id[31:0]  : bus_req.wdata;

  logic [31:0] id_upper_q;
  logic [31:0] id_lower_q;
  logic        lock_upper;
  logic        lock_lower;

  // upper quadlet: maker field and serial upper, third bus info quadlet
  ogr_id_reg u_id_upper (                                               // see RQ2
    .clock      (clock),
    .rst_b      (rst_b),
    .pcie_rst_b (any_rst_b),
    .load       (ld_upper),
    .load_data  (ld_upper_d),
    .value      (id_upper_q),
    .locked     (lock_upper)
  );

  // lower quadlet: serial lower, same lock and reset behaviour
  ogr_id_reg u_id_lower (                                               // see RQ7
    .clock      (clock),
    .rst_b      (rst_b),
    .pcie_rst_b (any_rst_b),
    .load       (ld_lower),
    .load_data  (ld_lower_d),
    .value      (id_lower_q),
    .locked     (lock_lower)
  );

  // zero is an illegal identifier, so report validity only after both loads
  assign unique_id = {id_upper_q, id_lower_q};
  assign id_valid  = lock_upper & lock_lower;                           // see RQ1

  // -----------------------------------------------------------------
  // configuration rom mapping
  // -----------------------------------------------------------------
  logic [31:OGR_ROM_LSB] rom_base_field;

  // software writable base, low bits are not stored at all
  always_ff @(posedge clock or negedge any_rst_b)
  begin
    if (!any_rst_b)
      rom_base_field <= OGR_ROM_RESET[31:OGR_ROM_LSB];                  // see RQ9
    else if (bus_req.wr & hit_rom)
      rom_base_field <= bus_req.wdata[31:OGR_ROM_LSB];                  // see RQ9
  end

  wire [31:0] rom_base_word = {rom_base_field, {OGR_ROM_LSB{1'b0}}};   // see RQ10
  wire        rom_in_win    = (rom_rd_offset >= OGR_ROM_WIN_LO) &
                              (rom_rd_offset <= OGR_ROM_WIN_HI);
  // base is 1 KiB aligned, so the add never carries out of the low ten bits
  wire [31:0] next_rom_addr = rom_base_word +
                              {{(32-OGR_ROM_OFF_W){1'b0}},
                               rom_rd_offset[OGR_ROM_OFF_W-1:0]};

  // translated host address registered one cycle after the request
  always_ff @(posedge clock or negedge any_rst_b)
  begin
    if (!any_rst_b)
    begin
      rom_host_addr  <= 32'h0000_0000;
      rom_host_valid <= 1'b0;
    end
    else
    begin
      rom_host_valid <= rom_rd_req & rom_in_win;                        // see RQ8
      if (rom_rd_req & rom_in_win)
        rom_host_addr <= next_rom_addr;                                 // see RQ8
    end
  end

  // -----------------------------------------------------------------
  // posted-write error capture
  // -----------------------------------------------------------------
  // contents are undefined until a failure; no reset keeps them cheap
  logic [31:0] failed_write_offset_low;
  logic [31:0] failed_write_source_offset_high;

  always_ff @(posedge clock)
  begin
    if (fail_event)
    begin
      failed_write_offset_low         <= fail_info.dest_offset[31:0];   // see RQ11 see RQ12
      failed_write_source_offset_high <= {fail_info.bus_num,            // see RQ13
                                          fail_info.node_num,
                                          fail_info.dest_offset[47:32]}; // see RQ14
    end
  end

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  wire [31:0] next_rdata = hit_upper ? id_upper_q :
                           hit_lower ? id_lower_q :
                           hit_rom   ? rom_base_word :
                           hit_flo   ? failed_write_offset_low :
                           hit_fhi   ? failed_write_source_offset_high :
                                       32'h0000_0000;   // unmapped reads zero

  always_ff @(posedge clock or negedge any_rst_b)
  begin
    if (!any_rst_b)
    begin
      rdata  <= 32'h0000_0000;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= bus_req.rd;
      if (bus_req.rd)
        rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// [rtl/ogr_pkg.sv]
// Summary of operation
// RQ1 - upper identifier resets to zero, invalid
// RQ2 - upper identifier holds maker and serial
// RQ3 - eeprom load then writes ignored
// RQ4 - firmware loads once when no eeprom
// RQ5 - upper identifier cleared by any reset; the pcie reset here leaves bits 3..0 unchanged
// RQ6 - bits 3..0 survive the pcie reset
// RQ7 - lower identifier at 28h, same behaviour
// RQ8 - rom read address is base plus offset
// RQ9 - rom base bits 31..10 writable, zero reset
// RQ10 - rom base bits 9..0 read zero
// RQ11 - failed posted write updates error registers
// RQ12 - low error register holds offset low
// RQ13 - high register holds bus and node
// RQ14 - high register low half holds offset high
// RQ15 - lock flag set by load, cleared by reset
package ogr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OGR_OFF_ID_UPPER   = 8'h24;
  localparam logic [7:0] OGR_OFF_ID_LOWER   = 8'h28;
  localparam logic [7:0] OGR_OFF_ROM_BASE   = 8'h34;
  localparam logic [7:0] OGR_OFF_FAIL_LOW   = 8'h38;
  localparam logic [7:0] OGR_OFF_FAIL_HIGH  = 8'h3c;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int          OGR_STICKY_W      = 4;
  localparam int          OGR_ROM_LSB       = 10;
  localparam int          OGR_ROM_OFF_W     = 10;
  localparam logic [31:0] OGR_ID_RESET      = 32'h0000_0000;
  localparam logic [31:0] OGR_ROM_RESET     = 32'h0000_0000;
  localparam logic [47:0] OGR_ROM_WIN_LO    = 48'hffff_f000_0400;
  localparam logic [47:0] OGR_ROM_WIN_HI    = 48'hffff_f000_07ff;

  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ogr_req_s;

  // posted-write failure report
  typedef struct packed {
    logic [9:0]  bus_num;
    logic [5:0]  node_num;
    logic [47:0] dest_offset;
  } ogr_fail_s;

  // identifier load source
  typedef enum logic [1:0] {
    OGR_LD_NONE     = 2'b00,
    OGR_LD_EEPROM   = 2'b01,
    OGR_LD_FIRMWARE = 2'b10
  } ogr_ld_e;

endpackage

// [rtl/ogr_id_reg.sv]
`timescale 1ns/1ps
`default_nettype none
// one identifier quadlet with write-once lock and split reset domains
module ogr_id_reg
  import ogr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        pcie_rst_b,
  input  wire logic        load,
  input  wire logic [31:0] load_data,
  output logic      [31:0] value,
  output logic             locked
);
  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [31:OGR_STICKY_W]   upper_part;
  logic [OGR_STICKY_W-1:0]  sticky_part;
  wire                      take = load & ~locked;   // see RQ3 see RQ4

  // high bits and lock follow every reset source
  always_ff @(posedge clock or negedge pcie_rst_b)
  begin
    if (!pcie_rst_b)
    begin
      upper_part <= OGR_ID_RESET[31:OGR_STICKY_W];   // see RQ1 see RQ5
      locked     <= 1'b0;                            // see RQ15
    end
    else if (take)
    begin
      upper_part <= load_data[31:OGR_STICKY_W];
      locked     <= 1'b1;                            // see RQ15
    end
  end

  // low nibble ignores the pcie reset
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sticky_part <= OGR_ID_RESET[OGR_STICKY_W-1:0]; // see RQ6
    else if (take)
      sticky_part <= load_data[OGR_STICKY_W-1:0];
  end

  assign value = {upper_part, sticky_part};
endmodule
`default_nettype wire

// [sim/ogr_chk_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------
// port checks of the register bank
// -----------------------------------------
module ogr_chk
  import ogr_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              pcie_rst_b,
  input wire ogr_pkg::ogr_req_s bus_req,
  input wire logic [31:0]       rdata,
  input wire logic              eeprom_present,
  input wire logic              eeprom_load,
  input wire logic [63:0]       eeprom_id,
  input wire logic              rom_rd_req,
  input wire logic [47:0]       rom_rd_offset,
  input wire logic [31:0]       rom_host_addr,
  input wire logic              rom_host_valid,
  input wire logic [63:0]       unique_id,
  input wire logic              id_valid
);
  import ogr_pkg::*;
  localparam logic [63:0] KEEP = 64'h0000_000f_0000_000f;
  logic [31:0] base;
  wire         win = rom_rd_req && rom_rd_offset >= OGR_ROM_WIN_LO
                     && rom_rd_offset <= OGR_ROM_WIN_HI;
  wire  [31:0] sum = base + {22'h0, rom_rd_offset[9:0]};
  wire         rd_rom = bus_req.rd && bus_req.addr == OGR_OFF_ROM_BASE;
  // shadow of the rom base, because the bank itself is hidden from here
  always_ff @(posedge clock or negedge rst_b or negedge pcie_rst_b)
    if (!rst_b || !pcie_rst_b)
      base <= '0;
    else if (bus_req.wr && bus_req.addr == OGR_OFF_ROM_BASE)
      base <= bus_req.wdata & 32'hffff_fc00;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b || !pcie_rst_b);
  a_rom_sum: assert property (win |=> rom_host_valid && rom_host_addr == $past(sum))
    else $error("rom host address wrong");
  a_rom_quiet: assert property (!win |=> !rom_host_valid)
    else $error("rom answer without request");
  a_rom_low_zero: assert property (rd_rom |=> rdata[9:0] == 10'h0)
    else $error("rom base low bits not zero");
  a_lock_hold: assert property (id_valid |=> id_valid && $stable(unique_id))
    else $error("locked identifier changed");
  a_ee_load: assert property (eeprom_present && eeprom_load && !id_valid
    |=> id_valid && unique_id == $past(eeprom_id)) else $error("eeprom load missed");
  a_ee_no_write: assert property (eeprom_present && bus_req.wr && !eeprom_load
    |=> $stable(unique_id)) else $error("identifier written with eeprom");
  a_pcie_clear: assert property (disable iff (!rst_b) !pcie_rst_b
    |-> (unique_id & ~KEEP) == 64'h0 && !id_valid) else $error("pcie reset left id");
  a_sticky_bits: assert property (disable iff (!rst_b) $fell(pcie_rst_b)
    |-> ((unique_id ^ $past(unique_id)) & KEEP) == 64'h0) else $error("sticky bits lost");
  c_ee_load: cover property (eeprom_present && eeprom_load);
  c_rom_read: cover property (win);
  c_pcie_reset: cover property (disable iff (!rst_b) $fell(pcie_rst_b));
endmodule
bind ogr_regs ogr_chk u_chk (.clock, .rst_b, .pcie_rst_b, .bus_req, .rdata, .eeprom_present,
  .eeprom_load, .eeprom_id, .rom_rd_req, .rom_rd_offset, .rom_host_addr, .rom_host_valid,
  .unique_id, .id_valid);
`default_nettype wire

// [sim/ogr_requester.sv]
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------
// remote requester: rom reads, failed writes
// -----------------------------------------
module ogr_requester
  import ogr_pkg::*;
(
  input  wire logic         clock,
  output logic              fail_event,
  output ogr_pkg::ogr_fail_s fail_info,
  output logic              rom_rd_req,
  output logic [47:0]       rom_rd_offset
);
  import ogr_pkg::*;
  // released lines carry the inverse of the last value, never a hold
  initial
  begin
    fail_event = 1'b0;
    fail_info = '1;
    rom_rd_req = 1'b0;
    rom_rd_offset = '1;
  end
  task automatic rom(input logic [47:0] o);
    rom_rd_req <= 1'b1;
    rom_rd_offset <= o;
    @(posedge clock);
    rom_rd_req <= 1'b0;
    rom_rd_offset <= ~o;
    @(posedge clock);
  endtask
  task automatic fail(input ogr_fail_s f);
    fail_event <= 1'b1;
    fail_info <= f;
    @(posedge clock);
    fail_event <= 1'b0;
    fail_info <= ~f;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// [sim/test_ogr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_ogr_regs;
  import ogr_pkg::*;
  logic        clock = 1'b0, rst_b = 1'b0, pcie_rst_b = 1'b0, eeprom_present = 1'b0;
  logic        eeprom_load = 1'b0, rvalid, rom_host_valid, id_valid, rom_rd_req, fail_event;
  logic [31:0] rdata, rom_host_addr, u, l, b, exp_q[$], rom_q[$];
  logic [47:0] rom_rd_offset, o;
  logic [63:0] unique_id, eeprom_id = '0;
  ogr_req_s    bus_req = '0;
  ogr_fail_s   fail_info;
  int          fails = 0, comparisons = 0, cycles = 0, seed = 32'h61638ede;
  always #25 clock = ~clock;
  ogr_regs uut (.clock, .rst_b, .pcie_rst_b, .bus_req, .rdata, .rvalid, .eeprom_present,
    .eeprom_load, .eeprom_id, .rom_rd_req, .rom_rd_offset, .rom_host_addr,
    .rom_host_valid, .fail_event, .fail_info, .unique_id, .id_valid);
  ogr_requester far (.clock, .fail_event, .fail_info, .rom_rd_req, .rom_rd_offset);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // idle bus shows inverted leftovers so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    bus_req <= '{1'b0, 1'b0, ~a, ~d};
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    bus_req <= '{1'b0, 1'b0, ~a, 32'hffff_ffff};
    @(posedge clock);
  endtask
  // answers meet the oldest note; a missing note pops unknown and fails
  always @(posedge clock)
  begin
    if (rvalid === 1'b1)
      chk(rdata, exp_q.pop_front());
    if (rom_host_valid === 1'b1)
      chk(rom_host_addr, rom_q.pop_front());
    if (++cycles == 3000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    pcie_rst_b <= 1'b1;
    @(posedge clock);
    rd(OGR_OFF_ID_UPPER, OGR_ID_RESET);
    rd(OGR_OFF_ID_LOWER, OGR_ID_RESET);
    rd(OGR_OFF_ROM_BASE, OGR_ROM_RESET);
    rd(8'h30, 32'h0);
    b = $random(seed);
    wr(OGR_OFF_ROM_BASE, b);
    rd(OGR_OFF_ROM_BASE, b & 32'hffff_fc00);
    // both window edges, two inside, then one just past the top
    for (int i = 0; i < 5; i++)
    begin
      o = (i < 4) ? OGR_ROM_WIN_LO + 48'(i * 341) : OGR_ROM_WIN_HI + 48'h1;
      if (i < 4)
        rom_q.push_back((b & 32'hffff_fc00) + {22'h0, o[9:0]});
      far.rom(o);
    end
    u = $random(seed);
    l = $random(seed);
    wr(OGR_OFF_ID_UPPER, u);
    wr(OGR_OFF_ID_UPPER, ~u);
    rd(OGR_OFF_ID_UPPER, u);
    wr(OGR_OFF_ID_LOWER, l);
    wr(OGR_OFF_ID_LOWER, ~l);
    rd(OGR_OFF_ID_LOWER, l);
    chk(unique_id[63:32], u);
    pcie_rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    pcie_rst_b <= 1'b1;
    @(posedge clock);
    rd(OGR_OFF_ID_UPPER, u & 32'hf);
    rd(OGR_OFF_ID_LOWER, l & 32'hf);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    eeprom_present <= 1'b1;
    eeprom_id <= {~u, ~l};
    @(posedge clock);
    wr(OGR_OFF_ID_UPPER, u);
    rd(OGR_OFF_ID_UPPER, 32'h0);
    // a second load with other data must be ignored
    repeat (2)
    begin
      eeprom_load <= 1'b1;
      @(posedge clock);
      eeprom_load <= 1'b0;
      eeprom_id <= {u, l};
      @(posedge clock);
    end
    wr(OGR_OFF_ID_LOWER, u);
    rd(OGR_OFF_ID_UPPER, ~u);
    rd(OGR_OFF_ID_LOWER, ~l);
    repeat (2)
    begin
      b = $random(seed);
      o = {b[31:16], 32'($random(seed))};
      far.fail({b[15:0], o});
    end
    rd(OGR_OFF_FAIL_LOW, o[31:0]);
    rd(OGR_OFF_FAIL_HIGH, {b[15:0], o[47:32]});
    summarize();
  end
endmodule
`default_nettype wire
